// ### core/t1bp_estore.sv
// receive elastic store: two 193-bit frames, frame-granular slips
`include "t1bp_map.svh"
module t1bp_estore (
	input  wire logic core_clk,      // backplane side clock
	input  wire logic srst,          // sync reset, core_clk domain
	input  wire logic rx_line_clk,   // recovered line clock
	input  wire logic rx_line_data,  // line data, rx_line_clk domain
	input  wire logic rx_line_frame, // high on the frame bit
	t1bp_es_if.store  es             // read side
);
	logic       mem [0:`T1BP_STORE_BITS-1];
	logic       lrst_s1;
	logic       lrst_q;
	logic [7:0] wr_bit_q;
	logic [7:0] wr_pos;
	logic [1:0] wr_frm_q;
	logic [1:0] wr_gray_q;
	logic [1:0] g_s1;
	logic [1:0] g_s2;
	logic [1:0] wr_bin;
	logic [1:0] rd_frm_q;
	logic [1:0] avail;

	function automatic logic [8:0] addr(input logic slot,
		input logic [7:0] b);
		addr = slot ? ({1'b0, b} + `T1BP_FRAME_BITS) : {1'b0, b};
	endfunction : addr

	// the line domain gets its own copy of the reset
	always_ff @(posedge rx_line_clk)
	begin
		lrst_s1 <= srst;
		lrst_q  <= lrst_s1;
	end

	assign wr_pos = rx_line_frame ? 8'h00 : wr_bit_q;

	always_ff @(posedge rx_line_clk)
		mem[addr(wr_frm_q[0], wr_pos)] <= rx_line_data;

	// only a gray frame count crosses: one bit changes per frame
	always_ff @(posedge rx_line_clk)
	begin
		if (lrst_q)
		begin
			wr_bit_q  <= 8'h00;
			wr_frm_q  <= 2'h0;
			wr_gray_q <= 2'h0;
		end
		else if (wr_pos == `T1BP_LAST_T1_BIT)
		begin
			wr_bit_q  <= 8'h00;
			wr_frm_q  <= wr_frm_q + 2'h1;
			wr_gray_q <= (wr_frm_q + 2'h1) ^ ((wr_frm_q + 2'h1) >> 1);
		end
		else
			wr_bit_q <= wr_pos + 8'h01;
	end

	always_ff @(posedge core_clk)
	begin
		g_s1 <= wr_gray_q;
		g_s2 <= g_s1;
	end

	assign wr_bin        = {g_s2[1], g_s2[1] ^ g_s2[0]};
	assign avail         = wr_bin - rd_frm_q;
	assign es.slip_empty = es.frame_end && (avail < 2'h2);
	assign es.slip_full  = es.frame_end && (avail == 2'h3);
	assign es.rd_data    = mem[addr(rd_frm_q[0], es.rd_bit)];

	// empty repeats the frame just read, full skips one whole frame
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rd_frm_q <= 2'h0;
		else if (es.slip_full)
			rd_frm_q <= rd_frm_q + 2'h2;
		else if (es.frame_end && !es.slip_empty)
			rd_frm_q <= rd_frm_q + 2'h1;
	end
endmodule : t1bp_estore

// ### core/t1bp_top.sv
// backplane channel path: registers, receive backplane side, tx path
`include "t1bp_map.svh"
// Notes on behaviour
// - 24 receive mark bits in three bytes, channel 1 at bit 0.
// - marked channel becomes idle code or milliwatt, else passes.
// - the idle code for marked channels is 7F hex.
// - milliwatt repeats 1E 0B 0B 1E 9E 8B 8B 9E, one byte per marked channel in turn.
// - code-insert bit set overwrites channel with its own code byte.
// - code-insert bits in three bytes at 1B to 1D.
// - codes for channels 1-16 at 80-8F, channels 17-24 at 58-5F.
// - loopback select makes idle bits choose receive data per channel.
// - in loopback a zero takes serial input, a one receive data.
// - receive blocking bit holds receive block output high per channel.
// - transmit blocking bit holds transmit block output high.
// - two-frame elastic store with controlled slips.
// - backplane rate setting takes effect only with store enable set.
// - backplane clock may burst up to 8.192 MHz.
// - sync pin is input, or output at frame or multiframe starts.
// - frame sync always marked; multiframe sync only with store on.
// - at 2.048 MHz every fourth slot is all ones, F bit in slot 0.
// - at 2.048 MHz block output is high in the all-ones slots.
// - empty store repeats one frame, sets slip and empty flags.
// - full store drops one frame, sets slip and full flags.
module t1bp_top (
	input  wire logic       core_clk,               // system clock
	input  wire logic       srst,                   // sync reset
	input  wire logic [7:0] reg_addr,               // register address
	input  wire logic [7:0] reg_wdata,              // write data
	input  wire logic       reg_wr,                 // write strobe
	input  wire logic       reg_rd,                 // read strobe
	output logic      [7:0] reg_rdata,              // read data
	input  wire logic       rx_line_clk,            // recovered line clock
	input  wire logic       rx_line_data,           // framer data
	input  wire logic       rx_line_frame,          // framer F-bit mark
	input  wire logic       rx_system_clock,        // backplane clock
	input  wire logic       rx_backplane_sync_in,   // sync pin input
	output logic            rx_backplane_sync_out,  // sync pin output
	output logic            rx_backplane_sync_oe,   // sync pin enable
	output logic            rx_serial_out,          // backplane data
	output logic            rx_channel_block_out,   // receive ch block
	output logic            rx_frame_sync_out,      // frame boundary
	output logic            rx_multiframe_sync_out, // multiframe mark
	input  wire logic       tx_line_clock,          // transmit clock
	input  wire logic       tx_sync,                // transmit sync
	input  wire logic       tx_serial_in,           // backplane tx data
	output logic            tx_line_data,           // transmit data
	output logic            tx_channel_block_out    // transmit ch block
);
	t1bp_pkg::t1bp_chmask_t rx_ins_q;
	t1bp_pkg::t1bp_chmask_t rx_mark_q;
	t1bp_pkg::t1bp_chmask_t rx_blk_q;
	t1bp_pkg::t1bp_chmask_t tx_blk_q;
	t1bp_pkg::t1bp_chmask_t tx_idle_q;
	t1bp_pkg::t1bp_byte_t   code_q [0:23];
	t1bp_pkg::t1bp_byte_t   rx_ctl_q;
	t1bp_pkg::t1bp_byte_t   tx_ctl_q;
	t1bp_pkg::t1bp_byte_t   rd_mux;
	t1bp_pkg::t1bp_slot_s   slot;
	t1bp_pkg::t1bp_byte_t   ch_byte;
	logic                   slip_q;
	logic                   empty_q;
	logic                   full_q;
	logic                   st_clr;
	logic [5:0]             code_hit;
	logic [2:0]             sys_s;
	logic [2:0]             line_s;
	logic [2:0]             sync_s;
	logic                   step;
	logic                   pend_q;
	logic [7:0]             bit_q;
	logic [7:0]             cur;
	logic [7:0]             last_bit;
	logic [3:0]             mf_q;
	logic [3:0]             cur_mf;
	logic [2:0]             mw_q;
	logic                   ins_on;
	logic                   mark_on;
	logic                   out_bit;
	logic                   frame_end;

	t1bp_es_if es ();
	t1bp_tx_if txc ();

	wire es_en   = rx_ctl_q[`T1BP_CTL_ES_EN];
	wire e1_rate = rx_ctl_q[`T1BP_CTL_RATE] && es_en;
	wire sync_in = rx_ctl_q[`T1BP_CTL_SYNC_IN];
	wire sync_mf = rx_ctl_q[`T1BP_CTL_SYNC_MF];
	wire mw_sel  = rx_ctl_q[`T1BP_CTL_MW_SEL];

	// bit 5 flags a hit, low bits give the channel
	function automatic logic [5:0] code_index(input logic [7:0] a);
		code_index = 6'h00;
		if (a >= `T1BP_CODE_LO_BASE && a <= `T1BP_CODE_LO_LAST)
			code_index = {2'b10, a[3:0]};
		else if (a >= `T1BP_CODE_HI_BASE && a <= `T1BP_CODE_HI_LAST)
			code_index = {1'b1, `T1BP_CODE_HI_FIRST + {2'b00, a[2:0]}};
	endfunction : code_index

	function automatic logic pick(input t1bp_pkg::t1bp_chmask_t m,
		input logic [4:0] ch);
		pick = (ch < `T1BP_NUM_CH) ? m[ch] : 1'b0;
	endfunction : pick

	function automatic t1bp_pkg::t1bp_byte_t mw_byte(input logic [2:0] i);
		case (i)
			3'h0: mw_byte = `T1BP_MW_0;
			3'h1: mw_byte = `T1BP_MW_1;
			3'h2: mw_byte = `T1BP_MW_2;
			3'h3: mw_byte = `T1BP_MW_3;
			3'h4: mw_byte = `T1BP_MW_4;
			3'h5: mw_byte = `T1BP_MW_5;
			3'h6: mw_byte = `T1BP_MW_6;
			default: mw_byte = `T1BP_MW_7;
		endcase
	endfunction : mw_byte

	// backplane bit position to line channel, bit and store index
	function automatic t1bp_pkg::t1bp_slot_s map_slot(input logic [7:0] b,
		input logic e1);
		t1bp_pkg::t1bp_slot_s s;
		logic [7:0]           bm1;
		logic [4:0]           ts;
		logic [4:0]           c;
		s   = '0;
		bm1 = b - 8'h01;
		ts  = b[7:3];
		c   = ts - {2'b00, ts[4:2]} - 5'd1;
		if (!e1)
		begin
			s.fbit = (b == 8'h00);
			s.ch   = bm1[7:3];
			s.pos  = bm1[2:0];
			s.idx  = b;
		end
		else if (ts[1:0] == 2'b00)
		begin
			s.fbit   = (b == 8'h00);
			s.filler = (b != 8'h00);
			s.ch     = 5'h1f;
			s.pos    = b[2:0];
			s.idx    = 8'h00;
		end
		else
		begin
			s.ch  = c;
			s.pos = b[2:0];
			s.idx = {c, b[2:0]} + 8'h01;
		end
		return s;
	endfunction : map_slot

	assign code_hit = code_index(reg_addr);
	assign st_clr   = reg_wr && (reg_addr == `T1BP_STATUS);

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rx_ins_q  <= `T1BP_MASK_RESET;
			rx_mark_q <= `T1BP_MASK_RESET;
			rx_blk_q  <= `T1BP_MASK_RESET;
			tx_blk_q  <= `T1BP_MASK_RESET;
			tx_idle_q <= `T1BP_MASK_RESET;
			rx_ctl_q  <= `T1BP_REG_RESET;
			tx_ctl_q  <= `T1BP_REG_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`T1BP_RX_INS_LO:   rx_ins_q[7:0]    <= reg_wdata;
				`T1BP_RX_INS_MID:  rx_ins_q[15:8]   <= reg_wdata;
				`T1BP_RX_INS_HI:   rx_ins_q[23:16]  <= reg_wdata;
				`T1BP_RX_MARK_LO:  rx_mark_q[7:0]   <= reg_wdata;
				`T1BP_RX_MARK_MID: rx_mark_q[15:8]  <= reg_wdata;
				`T1BP_RX_MARK_HI:  rx_mark_q[23:16] <= reg_wdata;
				`T1BP_RX_BLK_LO:   rx_blk_q[7:0]    <= reg_wdata;
				`T1BP_RX_BLK_MID:  rx_blk_q[15:8]   <= reg_wdata;
				`T1BP_RX_BLK_HI:   rx_blk_q[23:16]  <= reg_wdata;
				`T1BP_TX_BLK_LO:   tx_blk_q[7:0]    <= reg_wdata;
				`T1BP_TX_BLK_MID:  tx_blk_q[15:8]   <= reg_wdata;
				`T1BP_TX_BLK_HI:   tx_blk_q[23:16]  <= reg_wdata;
				`T1BP_TX_IDLE_LO:  tx_idle_q[7:0]   <= reg_wdata;
				`T1BP_TX_IDLE_MID: tx_idle_q[15:8]  <= reg_wdata;
				`T1BP_TX_IDLE_HI:  tx_idle_q[23:16] <= reg_wdata;
				`T1BP_RX_CTL:      rx_ctl_q         <= reg_wdata;
				`T1BP_TX_CTL:      tx_ctl_q         <= reg_wdata;
				default:           rx_ctl_q         <= rx_ctl_q;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < 24; i++)
				code_q[i] <= `T1BP_REG_RESET;
		end
		else if (reg_wr && code_hit[5])
			code_q[code_hit[4:0]] <= reg_wdata;
	end

	// a slip in the same cycle as the clear keeps its flag set
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			slip_q  <= 1'b0;
			empty_q <= 1'b0;
			full_q  <= 1'b0;
		end
		else
		begin
			slip_q <= es.slip_empty || es.slip_full ||
				(slip_q && !(st_clr && reg_wdata[`T1BP_ST_SLIP]));
			empty_q <= es.slip_empty ||
				(empty_q && !(st_clr && reg_wdata[`T1BP_ST_EMPTY]));
			full_q <= es.slip_full ||
				(full_q && !(st_clr && reg_wdata[`T1BP_ST_FULL]));
		end
	end

	always_comb
	begin
		rd_mux = `T1BP_REG_RESET;
		case (reg_addr)
			`T1BP_RX_INS_LO:   rd_mux = rx_ins_q[7:0];
			`T1BP_RX_INS_MID:  rd_mux = rx_ins_q[15:8];
			`T1BP_RX_INS_HI:   rd_mux = rx_ins_q[23:16];
			`T1BP_RX_MARK_LO:  rd_mux = rx_mark_q[7:0];
			`T1BP_RX_MARK_MID: rd_mux = rx_mark_q[15:8];
			`T1BP_RX_MARK_HI:  rd_mux = rx_mark_q[23:16];
			`T1BP_RX_BLK_LO:   rd_mux = rx_blk_q[7:0];
			`T1BP_RX_BLK_MID:  rd_mux = rx_blk_q[15:8];
			`T1BP_RX_BLK_HI:   rd_mux = rx_blk_q[23:16];
			`T1BP_TX_BLK_LO:   rd_mux = tx_blk_q[7:0];
			`T1BP_TX_BLK_MID:  rd_mux = tx_blk_q[15:8];
			`T1BP_TX_BLK_HI:   rd_mux = tx_blk_q[23:16];
			`T1BP_TX_IDLE_LO:  rd_mux = tx_idle_q[7:0];
			`T1BP_TX_IDLE_MID: rd_mux = tx_idle_q[15:8];
			`T1BP_TX_IDLE_HI:  rd_mux = tx_idle_q[23:16];
			`T1BP_RX_CTL:      rd_mux = rx_ctl_q;
			`T1BP_TX_CTL:      rd_mux = tx_ctl_q;
			`T1BP_STATUS:      rd_mux = {5'h00, full_q, empty_q, slip_q};
			default:
			begin
				if (code_hit[5])
					rd_mux = code_q[code_hit[4:0]];
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			reg_rdata <= `T1BP_REG_RESET;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// backplane clock is oversampled; bursts to 8.192 MHz stay well resolved
	always_ff @(posedge core_clk)
	begin
		sys_s  <= {sys_s[1:0], rx_system_clock};
		line_s <= {line_s[1:0], rx_line_clk};
		sync_s <= {sync_s[1:0], rx_backplane_sync_in};
	end

	// without the store the backplane side follows the line bit rate
	assign step = es_en ? (sys_s[1] && !sys_s[2]) :
		(line_s[1] && !line_s[2]);

	always_ff @(posedge core_clk)
	begin
		if (srst)
			pend_q <= 1'b0;
		else if (sync_in && sync_s[1] && !sync_s[2])
			pend_q <= 1'b1;
		else if (step)
			pend_q <= 1'b0;
	end

	assign last_bit  = e1_rate ? `T1BP_LAST_E1_BIT : `T1BP_LAST_T1_BIT;
	assign cur       = pend_q ? 8'h00 : bit_q;
	assign cur_mf    = (pend_q && sync_mf) ? 4'h0 : mf_q;
	assign frame_end = step && (cur == last_bit);
	assign slot      = map_slot(cur, e1_rate);

	assign es.rd_bit    = slot.idx;
	assign es.frame_end = frame_end;

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			bit_q <= 8'h00;
			mf_q  <= 4'h0;
		end
		else if (step)
		begin
			bit_q <= (cur == last_bit) ? 8'h00 : cur + 8'h01;
			if (cur == last_bit)
				mf_q <= (cur_mf == `T1BP_MF_LAST) ? 4'h0 : cur_mf + 4'h1;
			else
				mf_q <= cur_mf;
		end
	end

	assign ins_on  = !slot.fbit && !slot.filler && pick(rx_ins_q, slot.ch);
	assign mark_on = !slot.fbit && !slot.filler && pick(rx_mark_q, slot.ch);

	// code insertion outranks marking when both are set on a channel
	always_comb
	begin
		ch_byte = `T1BP_IDLE_CODE;
		if (ins_on)
			ch_byte = code_q[slot.ch];
		else if (mw_sel)
			ch_byte = mw_byte(mw_q);
		out_bit = es.rd_data;
		if (slot.filler)
			out_bit = 1'b1;
		else if (ins_on || mark_on)
			out_bit = ch_byte[3'h7 - slot.pos];
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			mw_q <= 3'h0;
		else if (step && mark_on && !ins_on && mw_sel && slot.pos == 3'h7)
			mw_q <= mw_q + 3'h1;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rx_serial_out          <= 1'b1;
			rx_channel_block_out   <= 1'b0;
			rx_frame_sync_out      <= 1'b0;
			rx_multiframe_sync_out <= 1'b0;
			rx_backplane_sync_out  <= 1'b0;
		end
		else if (step)
		begin
			rx_serial_out        <= out_bit;
			rx_channel_block_out <= slot.filler || (!slot.fbit &&
				pick(rx_blk_q, slot.ch));
			rx_frame_sync_out      <= (cur == 8'h00);
			rx_multiframe_sync_out <= es_en && (cur == 8'h00) &&
				(cur_mf == 4'h0);
			rx_backplane_sync_out <= (cur == 8'h00) &&
				(!sync_mf || cur_mf == 4'h0);
		end
	end

	assign rx_backplane_sync_oe = !sync_in;

	assign txc.idle_bits  = tx_idle_q;
	assign txc.block_bits = tx_blk_q;
	assign txc.loop_sel   = tx_ctl_q[`T1BP_TXCTL_LOOP];

	t1bp_estore u_estore (
		.core_clk      (core_clk),
		.srst          (srst),
		.rx_line_clk   (rx_line_clk),
		.rx_line_data  (rx_line_data),
		.rx_line_frame (rx_line_frame),
		.es            (es)
	);

	t1bp_txpath u_txpath (
		.core_clk             (core_clk),
		.srst                 (srst),
		.tx_line_clock        (tx_line_clock),
		.tx_sync              (tx_sync),
		.tx_serial_in         (tx_serial_in),
		.rx_line_data         (rx_line_data),
		.cfg                  (txc),
		.tx_line_data         (tx_line_data),
		.tx_channel_block_out (tx_channel_block_out)
	);
endmodule : t1bp_top

// ### core/t1bp_txpath.sv
// transmit framing: per-channel loopback and transmit channel blocking
`include "t1bp_map.svh"
module t1bp_txpath (
	input  wire logic core_clk,             // system clock
	input  wire logic srst,                 // sync reset
	input  wire logic tx_line_clock,        // transmit bit clock pin
	input  wire logic tx_sync,              // transmit frame sync pin
	input  wire logic tx_serial_in,         // backplane transmit data
	input  wire logic rx_line_data,         // receive framer output
	t1bp_tx_if.path   cfg,                  // channel selects
	output logic      tx_line_data,         // transmit data to line
	output logic      tx_channel_block_out  // transmit channel block
);
	logic [2:0] clk_s;
	logic [2:0] sync_s;
	logic [1:0] ser_s;
	logic [1:0] rxd_s;
	logic [7:0] bit_q;
	logic [7:0] cur;
	logic [7:0] bm1;
	logic       pend_q;
	logic       edge_t;

	always_ff @(posedge core_clk)
	begin
		clk_s  <= {clk_s[1:0], tx_line_clock};
		sync_s <= {sync_s[1:0], tx_sync};
		ser_s  <= {ser_s[0], tx_serial_in};
		rxd_s  <= {rxd_s[0], rx_line_data};
	end

	assign edge_t = clk_s[1] && !clk_s[2];
	assign cur    = pend_q ? 8'h00 : bit_q;
	assign bm1    = cur - 8'h01;

	always_ff @(posedge core_clk)
	begin
		if (srst)
			pend_q <= 1'b0;
		else if (sync_s[1] && !sync_s[2])
			pend_q <= 1'b1;
		else if (edge_t)
			pend_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			bit_q <= 8'h00;
		else if (edge_t)
			bit_q <= (cur == `T1BP_LAST_T1_BIT) ? 8'h00 : cur + 8'h01;
	end

	// receive data is only bit-aligned when both clocks are tied together
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			tx_line_data         <= 1'b0;
			tx_channel_block_out <= 1'b0;
		end
		else if (edge_t)
		begin
			if (cur != 8'h00 && cfg.loop_sel && cfg.idle_bits[bm1[7:3]])
				tx_line_data <= rxd_s[1];
			else
				tx_line_data <= ser_s[1];
			tx_channel_block_out <= (cur != 8'h00) &&
				cfg.block_bits[bm1[7:3]];
		end
	end
endmodule : t1bp_txpath

// ### dv/t1bp_bp_model.sv
// backplane partner: system clock source, capture of channels 1 and 2
module t1bp_bp_model (
	output logic        rx_system_clock,      // backplane clock
	output logic        rx_backplane_sync_in, // sync pin, left idle
	input  wire logic   rx_serial_out,        // backplane data
	input  wire logic   rx_channel_block_out, // channel block
	input  wire logic   rx_frame_sync_out,    // frame mark
	output logic [15:0] data_q,               // channels 1 and 2
	output logic [15:0] blk_q,                // block level
	output logic        got_q                 // capture done
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 99;
	initial
	begin
		rx_system_clock = 1'b0;
		got_q = 1'b0;
	end
	// the device owns the sync pin in every scenario, so hold it low
	assign rx_backplane_sync_in = 1'b0;
	// half again slower than the line: the store fills and slips steadily
	always #24 rx_system_clock = ~rx_system_clock;
	// a bit is taken one edge late, long after the output settled
	always @(posedge rx_system_clock)
	begin
		if (rx_frame_sync_out)
			cnt = 1;
		else if (cnt <= 16)
		begin
			data_q = {data_q[14:0], rx_serial_out};
			blk_q = {blk_q[14:0], rx_channel_block_out};
			got_q = (cnt == 16);
			cnt++;
		end
	end
endmodule : t1bp_bp_model

// ### dv/t1bp_chk.sv
// assertion checker on the ports of the backplane channel path top
`include "t1bp_map.svh"
module t1bp_chk (
	input wire logic       core_clk,               // clock
	input wire logic       srst,                   // reset
	input wire logic [7:0] reg_addr,               // address
	input wire logic [7:0] reg_wdata,              // write data
	input wire logic       reg_wr,                 // write
	input wire logic       reg_rd,                 // read
	input wire logic [7:0] reg_rdata,              // read data
	input wire logic       rx_backplane_sync_oe,   // sync enable
	input wire logic       rx_frame_sync_out,      // frame mark
	input wire logic       rx_multiframe_sync_out  // multiframe mark
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic es_q;
	always_ff @(posedge core_clk)
	begin
		if (srst)
			es_q <= 1'b0;
		else if (reg_wr && reg_addr == `T1BP_RX_CTL)
			es_q <= reg_wdata[`T1BP_CTL_ES_EN];
	end
	// write, one idle cycle, read back the same place
	property p_rdbk(a);
		reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a
			|=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	AST_MARK_RDBK: assert property (p_rdbk(`T1BP_RX_MARK_LO))
		else $error("mark byte readback wrong");
	AST_INS_RDBK: assert property (p_rdbk(`T1BP_RX_INS_LO))
		else $error("insert control readback wrong");
	AST_CODE_RDBK: assert property (p_rdbk(`T1BP_CODE_LO_BASE))
		else $error("low code register readback wrong");
	AST_CODE_HI_RDBK: assert property (p_rdbk(`T1BP_CODE_HI_BASE))
		else $error("high code register readback wrong");
	AST_RBLK_RDBK: assert property (p_rdbk(`T1BP_RX_BLK_LO))
		else $error("rx block readback wrong");
	AST_TBLK_RDBK: assert property (p_rdbk(`T1BP_TX_BLK_LO))
		else $error("tx block readback wrong");
	AST_SYNC_OE: assert property (reg_wr && reg_addr == `T1BP_RX_CTL
		|=> rx_backplane_sync_oe == !$past(reg_wdata[`T1BP_CTL_SYNC_IN]))
		else $error("sync pin direction wrong");
	// a new mark is launched from the setting one cycle back
	AST_MF_STORE: assert property ($rose(rx_multiframe_sync_out)
		|-> es_q || $past(es_q)) else $error("multiframe mark without store");
	AST_MF_FRAME: assert property (rx_multiframe_sync_out
		|-> rx_frame_sync_out) else $error("multiframe mark off frame start");
	cover property (rx_multiframe_sync_out);
	cover property ($rose(rx_frame_sync_out));
	cover property (reg_wr && reg_addr == `T1BP_RX_CTL);
endmodule : t1bp_chk

bind t1bp_top t1bp_chk i_t1bp_chk (.core_clk, .srst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .rx_backplane_sync_oe,
	.rx_frame_sync_out, .rx_multiframe_sync_out);

// ### dv/t1bp_top_tb.sv
// testbench of the backplane channel path
module t1bp_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        rx_line_clk = 1'b0, rx_line_data = 1'b0, rx_line_frame = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rdv;
	logic        rx_system_clock, sync_in, ser, blk, fs, mfs, oe, got;
	logic [15:0] data_w, blk_w;
	logic        txd, txb, so;
	int          fail_count = 0, compares = 0, lcnt = 0;
	t1bp_top i_t1bp_top (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rx_line_clk, .rx_line_data, .rx_line_frame,
		.rx_system_clock, .rx_backplane_sync_in(sync_in),
		.rx_backplane_sync_out(so), .rx_backplane_sync_oe(oe),
		.rx_serial_out(ser), .rx_channel_block_out(blk),
		.rx_frame_sync_out(fs), .rx_multiframe_sync_out(mfs),
		.tx_line_clock(rx_line_clk), .tx_sync(rx_line_frame),
		.tx_serial_in(1'b1), .tx_line_data(txd), .tx_channel_block_out(txb));
	t1bp_bp_model i_t1bp_bp_model (.rx_system_clock,
		.rx_backplane_sync_in(sync_in), .rx_serial_out(ser),
		.rx_channel_block_out(blk), .rx_frame_sync_out(fs),
		.data_q(data_w), .blk_q(blk_w), .got_q(got));
	always #5 core_clk = ~core_clk;
	// even offset keeps line edges off the rising core clock edges
	initial
	begin
		#2;
		forever #16 rx_line_clk = ~rx_line_clk;
	end
	// framer stream: F bit high, all payload zero
	always @(negedge rx_line_clk)
	begin
		lcnt = (lcnt == 192) ? 0 : lcnt + 1;
		rx_line_frame = (lcnt == 0);
		rx_line_data = (lcnt == 0);
	end
	task automatic end_sim;
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [15:0] e, s);
		compares++;
		if (s !== e)
		begin
			$display("MISMATCH %s exp %h got %h", n, e, s);
			fail_count++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge core_clk) #1 reg_wr = 1'b0;
		@(posedge core_clk) #1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk) #1 reg_rd = 1'b0;
		rdv = reg_rdata;
		@(posedge core_clk) #1;
	endtask : rd
	// two whole frames, so the captured one began after the setup writes
	task automatic grab;
		int n;
		n = 0;
		for (int k = 0; k < 4 && n < 40000; n++)
		begin
			@(posedge core_clk) #1;
			if (got === k[0])
				k++;
		end
		if (n >= 40000)
		begin
			fail_count++;
			end_sim();
		end
	endtask : grab
	task automatic t_regs;
		logic [7:0] a [6] = '{8'h2d, 8'h1b, 8'h80, 8'h58, 8'h6c, 8'h32};
		for (int i = 0; i < 6; i++)
		begin
			rd(a[i]);
			chk("reset value", 8'h00, rdv);
			wr(a[i], 8'h5a ^ a[i]);
			rd(a[i]);
			chk("readback", 8'h5a ^ a[i], rdv);
			wr(a[i], 8'h00);
		end
		rd(8'h00);
		chk("unmapped read", 8'h00, rdv);
	endtask : t_regs
	task automatic t_insert;
		wr(8'h70, 8'h01);
		wr(8'h1b, 8'h01);
		wr(8'h80, 8'ha5);
		wr(8'h2d, 8'h02);
		wr(8'h6c, 8'h01);
		grab();
		chk("channels 1 and 2", 16'ha57f, data_w);
		chk("rx block", 16'hff00, blk_w);
		grab();
		rd(8'h72);
		chk("full slip flags", 8'h05, rdv & 8'h05);
	endtask : t_insert
	task automatic t_e1;
		wr(8'h70, 8'h03);
		grab();
		chk("e1 data", 16'hff4a, data_w);
		chk("e1 block", 16'hfffe, blk_w);
	endtask : t_e1
	task automatic t_tx;
		int n;
		n = 0;
		wr(8'h3c, 8'h01);
		wr(8'h32, 8'h02);
		wr(8'h71, 8'h01);
		repeat (2) @(posedge rx_line_clk);
		while (lcnt != 2 && n < 400)
		begin
			@(posedge rx_line_clk);
			n++;
		end
		if (n >= 400)
		begin
			fail_count++;
			end_sim();
		end
		// the outputs still show the bit before the one now on the line
		chk("looped ch1 bit", 2'b00, {txd, txb});
		repeat (8) @(posedge rx_line_clk);
		chk("ch2 bit", 2'b11, {txd, txb});
	endtask : t_tx
	task automatic t_mw;
		logic [7:0] mw [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
			8'h9e, 8'h8b, 8'h8b, 8'h9e};
		logic hit;
		hit = 1'b0;
		wr(8'h1b, 8'h00);
		wr(8'h2d, 8'h03);
		wr(8'h70, 8'h11);
		grab();
		for (int i = 0; i < 8; i++)
			if (data_w === {mw[i], mw[(i + 1) % 8]})
				hit = 1'b1;
		chk("milliwatt pair", 1'b1, hit);
	endtask : t_mw
	task automatic t_sync;
		int n;
		n = 0;
		while (mfs !== 1'b1 && n < 40000)
		begin
			@(posedge core_clk) #1;
			n++;
		end
		chk("multiframe mark", 1'b1, mfs);
		chk("frame mark", 1'b1, fs);
		chk("sync pin driven", 1'b1, oe);
		chk("sync pin out", 1'b1, so);
	endtask : t_sync
	initial
	begin
		repeat (8) @(posedge core_clk);
		#1 srst = 1'b0;
		t_regs();
		t_insert();
		t_e1();
		t_mw();
		t_tx();
		t_sync();
		end_sim();
	end
endmodule : t1bp_top_tb

// ### include/t1bp_if.sv
// interfaces between the top and its elastic store and transmit path
interface t1bp_es_if;
	logic [7:0] rd_bit;
	logic       rd_data;
	logic       frame_end;
	logic       slip_empty;
	logic       slip_full;
	modport store (input rd_bit, input frame_end, output rd_data,
		output slip_empty, output slip_full);
	modport user (output rd_bit, output frame_end, input rd_data,
		input slip_empty, input slip_full);
endinterface : t1bp_es_if

interface t1bp_tx_if;
	t1bp_pkg::t1bp_chmask_t idle_bits;
	t1bp_pkg::t1bp_chmask_t block_bits;
	logic                   loop_sel;
	modport path (input idle_bits, input block_bits, input loop_sel);
	modport cfg (output idle_bits, output block_bits, output loop_sel);
endinterface : t1bp_tx_if

// ### include/t1bp_map.svh
// register offsets, field positions, reset values and frame counts
`ifndef T1BP_MAP_SVH
`define T1BP_MAP_SVH

`define T1BP_RX_INS_LO     8'h1b
`define T1BP_RX_INS_MID    8'h1c
`define T1BP_RX_INS_HI     8'h1d
`define T1BP_RX_MARK_LO    8'h2d
`define T1BP_RX_MARK_MID   8'h2e
`define T1BP_RX_MARK_HI    8'h2f
`define T1BP_TX_BLK_LO     8'h32
`define T1BP_TX_BLK_MID    8'h33
`define T1BP_TX_BLK_HI     8'h34
`define T1BP_TX_IDLE_LO    8'h3c
`define T1BP_TX_IDLE_MID   8'h3d
`define T1BP_TX_IDLE_HI    8'h3e
`define T1BP_RX_BLK_LO     8'h6c
`define T1BP_RX_BLK_MID    8'h6d
`define T1BP_RX_BLK_HI     8'h6e
`define T1BP_RX_CTL        8'h70
`define T1BP_TX_CTL        8'h71
`define T1BP_STATUS        8'h72
`define T1BP_CODE_LO_BASE  8'h80
`define T1BP_CODE_LO_LAST  8'h8f
`define T1BP_CODE_HI_BASE  8'h58
`define T1BP_CODE_HI_LAST  8'h5f
`define T1BP_CODE_HI_FIRST 5'd16

`define T1BP_CTL_ES_EN     0
`define T1BP_CTL_RATE      1
`define T1BP_CTL_SYNC_IN   2
`define T1BP_CTL_SYNC_MF   3
`define T1BP_CTL_MW_SEL    4
`define T1BP_TXCTL_LOOP    0
`define T1BP_ST_SLIP       0
`define T1BP_ST_EMPTY      1
`define T1BP_ST_FULL       2

`define T1BP_REG_RESET     8'h00
`define T1BP_MASK_RESET    24'h000000
`define T1BP_NUM_CH        5'd24
`define T1BP_LAST_T1_BIT   8'd192
`define T1BP_LAST_E1_BIT   8'd255
`define T1BP_FRAME_BITS    9'd193
`define T1BP_STORE_BITS    386
`define T1BP_MF_LAST       4'd11
`define T1BP_IDLE_CODE     8'h7f
`define T1BP_MW_0          8'h1e
`define T1BP_MW_1          8'h0b
`define T1BP_MW_2          8'h0b
`define T1BP_MW_3          8'h1e
`define T1BP_MW_4          8'h9e
`define T1BP_MW_5          8'h8b
`define T1BP_MW_6          8'h8b
`define T1BP_MW_7          8'h9e

`endif

// ### include/t1bp_pkg.sv
// shared types of the backplane channel path
package t1bp_pkg;
	typedef logic [7:0]  t1bp_byte_t;
	typedef logic [23:0] t1bp_chmask_t;
	typedef struct packed {
		logic       fbit;
		logic       filler;
		logic [4:0] ch;
		logic [2:0] pos;
		logic [7:0] idx;
	} t1bp_slot_s;
endpackage : t1bp_pkg
